// File: src/usbd_params.svh
`ifndef USBD_PARAMS_SVH
`define USBD_PARAMS_SVH

`define USBD_REG_CTRL      12'h000
`define USBD_REG_VERSION   12'h004
`define USBD_REG_CLASS     12'h008
`define USBD_REG_PACKET    12'h00c
`define USBD_REG_IDS       12'h010
`define USBD_REG_RELEASE   12'h014
`define USBD_REG_STRINGS   12'h018
`define USBD_REG_HIER      12'h01c
`define USBD_REG_STATUS    12'h020
`define USBD_REG_ALT       12'h024
`define USBD_WIN_BASE      12'h100

`define USBD_RST_CTRL      32'h0000_0001
`define USBD_RST_VERSION   32'h0000_0200
`define USBD_RST_CLASS     32'h0000_0000
`define USBD_RST_PACKET    32'h0001_4040
`define USBD_RST_IDS       32'h0000_0000
`define USBD_RST_RELEASE   32'h0000_0100
`define USBD_RST_STRINGS   32'h0000_0000
`define USBD_RST_HIER      32'h0001_0009
`define USBD_RST_CFG_SEL   8'h01

`define USBD_MSK_CTRL      32'h0000_0001
`define USBD_MSK_HALF      32'h0000_ffff
`define USBD_MSK_THREE     32'h00ff_ffff
`define USBD_MSK_FULL      32'hffff_ffff

`define USBD_DEV_LEN       8'h12
`define USBD_QUAL_LEN      8'h0a
`define USBD_CFG_LEN       8'h09
`define USBD_TYPE_DEVICE   8'h01
`define USBD_TYPE_CONFIG   8'h02
`define USBD_TYPE_QUAL     8'h06
`define USBD_REQ_GET_DESC  8'h06
`define USBD_REQ_SET_CFG   8'h09
`define USBD_REQ_SET_IF    8'h0b
`define USBD_BCD_MIN       16'h0200
`define USBD_NUM_CONFIGS   8'h01
`define USBD_MPS_DEFAULT   8'h40

`define USBD_OFS_LEN       8'h00
`define USBD_OFS_TYPE      8'h01
`define USBD_OFS_W2_LO     8'h02
`define USBD_OFS_W2_HI     8'h03
`define USBD_OFS_CLASS     8'h04
`define USBD_OFS_SUB       8'h05
`define USBD_OFS_PROTO     8'h06
`define USBD_OFS_MPS       8'h07
`define USBD_OFS_VID_LO    8'h08
`define USBD_OFS_VID_HI    8'h09
`define USBD_OFS_PID_LO    8'h0a
`define USBD_OFS_PID_HI    8'h0b
`define USBD_OFS_REL_LO    8'h0c
`define USBD_OFS_REL_HI    8'h0d
`define USBD_OFS_IMFR      8'h0e
`define USBD_OFS_IPROD     8'h0f
`define USBD_OFS_ISER      8'h10
`define USBD_OFS_NCFG      8'h11
`define USBD_QOFS_NCFG     8'h08
`define USBD_QOFS_RSVD     8'h09
`define USBD_COFS_NIF      8'h04
`define USBD_COFS_SEL      8'h05
`define USBD_COFS_ISTR     8'h06

`define USBD_RESP_OKAY     2'h0
`define USBD_RESP_SLVERR   2'h2
`define USBD_RESP_DECERR   2'h3

`endif

// File: src/usbd_pkg.sv
package usbd_pkg;

    typedef enum logic [1:0] {
        USBD_IDLE  = 2'h0,
        USBD_FETCH = 2'h1,
        USBD_LOAD  = 2'h3,
        USBD_SEND  = 2'h2
    } usbd_state_e;

    typedef enum logic [1:0] {
        USBD_K_DEV  = 2'h0,
        USBD_K_QUAL = 2'h1,
        USBD_K_CFG  = 2'h2
    } usbd_kind_e;

endpackage : usbd_pkg

// File: src/usbd_mem.sv
`timescale 1ns/100ps

module usbd_mem #(
    parameter int AW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);

    logic [7:0] mem [0:(1<<AW)-1];

    // Not reset; software loads the image.
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : usbd_mem

// File: src/usbd_responder.sv
// Operation
// [RULE1] String indices at bytes 14-16, configuration count at 17.
// [RULE2] Qualifier holds length, type, version, class, packet size, count.
// [RULE3] Qualifier byte 9 is zero.
// [RULE4] Qualifier shows the speed not in use.
// [RULE5] Qualifier omits vendor, product, release and string fields.
// [RULE6] Qualifier version is at least 0200H.
// [RULE7] Full-speed-only device stalls a qualifier request.
// [RULE8] Host asks other-speed only after a good qualifier.
// [RULE9] Host fetches the qualifier with the qualifier type.
// [RULE10] Set-configuration with the byte 5 value configures.
// [RULE11] Configuration request returns the whole hierarchy.
// [RULE12] Configuration header: length, type, total, interfaces, value, string.
// [RULE13] Total length counts the whole hierarchy.
// [RULE14] At least one configuration with at least one interface.
// [RULE15] An endpoint serves one interface, except alternates.
// [RULE16] Alternates may change while configured.
// [RULE17] Endpoint-zero packet size is 8, 16, 32 or 64.
// [RULE18] Versions are binary-coded decimal.
// [RULE19] Multi-byte fields go low byte first.
// [RULE20] Responses are cut to the requested length.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "usbd_params.svh"

module usbd_responder #(
    parameter int AW = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        hs_mode,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_code,
    input  wire logic [15:0] req_value,
    input  wire logic [15:0] req_index,
    input  wire logic [15:0] req_length,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    output logic             req_done,
    output logic             req_error
);

    localparam int          NREG    = 8;
    localparam int          NUM_ALT = 4;
    localparam logic [12:0] WIN_END = 13'(32'h100 + 4 * (1 << AW));
    localparam logic [16:0] DEPTH   = 17'(1 << AW);

    localparam logic [31:0] RST [0:NREG-1] = '{
        `USBD_RST_CTRL, `USBD_RST_VERSION, `USBD_RST_CLASS, `USBD_RST_PACKET,
        `USBD_RST_IDS, `USBD_RST_RELEASE, `USBD_RST_STRINGS, `USBD_RST_HIER};
    localparam logic [31:0] MSK [0:NREG-1] = '{
        `USBD_MSK_CTRL, `USBD_MSK_HALF, `USBD_MSK_THREE, `USBD_MSK_THREE,
        `USBD_MSK_FULL, `USBD_MSK_HALF, `USBD_MSK_FULL, `USBD_MSK_THREE};

    // Index 0..7 writable, 8 status, 9 alternates, e window, f unmapped.
    function automatic logic [3:0] usbd_decode(input logic [11:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'h0};
        if (w >= `USBD_WIN_BASE && {1'b0, w} < WIN_END) begin
            usbd_decode = 4'he;
        end else if (w <= `USBD_REG_ALT) begin
            usbd_decode = w[5:2];
        end else begin
            usbd_decode = 4'hf;
        end
    endfunction : usbd_decode

    function automatic logic [31:0] usbd_strb(input logic [31:0] o,
                                              input logic [31:0] n,
                                              input logic [3:0]  s);
        for (int i = 0; i < 4; i++) begin
            o[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
        usbd_strb = o;
    endfunction : usbd_strb

    // Illegal packet sizes show as 64.
    function automatic logic [7:0] usbd_mps_ok(input logic [7:0] m);
        unique case (m)
            8'h08, 8'h10, 8'h20, 8'h40: usbd_mps_ok = m;
            default:                    usbd_mps_ok = `USBD_MPS_DEFAULT;
        endcase
    endfunction : usbd_mps_ok

    logic               aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [11:0]        aw_addr_r;
    logic [31:0]        w_data_r, rdata_r;
    logic [3:0]         w_strb_r;
    logic [1:0]         bresp_r, rresp_r;
    logic [31:0]        cfg_r [0:NREG-1];
    logic [7:0]         alt_r [0:NUM_ALT-1];
    logic [7:0]         cfg_sel_r, cur_cfg_r;
    logic               configured_r;

    wire                wr_fire = aw_got_r && w_got_r && !bvalid_r;
    wire  [3:0]         wr_idx  = usbd_decode(aw_addr_r);
    wire  [3:0]         rd_idx  = usbd_decode(s_axi_araddr);
    wire                ar_fire = s_axi_arvalid && !rvalid_r;
    wire  [11:0]        win_ofs = aw_addr_r - `USBD_WIN_BASE;
    wire  [AW-1:0]      win_adr = win_ofs[AW+1:2];
    wire                win_wr  = wr_fire && wr_idx == 4'he && w_strb_r[0];
    wire  [1:0]         wr_resp = (wr_idx == 4'hf) ? `USBD_RESP_DECERR :
                                  (wr_idx == 4'h8 || wr_idx == 4'h9) ?
                                  `USBD_RESP_SLVERR : `USBD_RESP_OKAY;

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_r  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r  <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_r  <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `USBD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_resp;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    genvar g;
    for (g = 0; g < NREG; g++) begin : g_reg
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg_r[g] <= RST[g];
            end else if (wr_fire && wr_idx == 4'(g)) begin
                cfg_r[g] <= usbd_strb(cfg_r[g], w_data_r, w_strb_r) & MSK[g];
            end
        end
    end

    wire        hs_capable = cfg_r[0][0];
    wire [15:0] ver        = cfg_r[1][15:0];
    wire [7:0]  dev_class  = cfg_r[2][7:0];
    wire [7:0]  dev_sub    = cfg_r[2][15:8];
    wire [7:0]  dev_proto  = cfg_r[2][23:16];
    wire [7:0]  mps_fs     = cfg_r[3][7:0];
    wire [7:0]  mps_hs     = cfg_r[3][15:8];
    wire [7:0]  other_cfgs = cfg_r[3][23:16];
    wire [15:0] hier_len   = cfg_r[7][15:0];
    wire [7:0]  num_if     = cfg_r[7][23:16];

    wire [7:0]  mps_cur    = usbd_mps_ok(hs_mode ? mps_hs : mps_fs); // [RULE17]
    wire [7:0]  mps_oth    = usbd_mps_ok(hs_mode ? mps_fs : mps_hs); // [RULE4]
    wire [15:0] qual_ver   = (ver < `USBD_BCD_MIN) ? `USBD_BCD_MIN : ver; // [RULE6]
    wire [7:0]  num_if_eff = (num_if == 8'h00) ? 8'h01 : num_if; // [RULE14]
    wire [15:0] cfg_floor  = (hier_len < 16'(`USBD_CFG_LEN)) ?
                             16'(`USBD_CFG_LEN) : hier_len;
    // The total is clamped to what the image can hold.
    wire [15:0] cfg_total  = ({1'b0, cfg_floor} > DEPTH) ?
                             DEPTH[15:0] : cfg_floor; // [RULE13]

    wire [31:0] status_w   = {8'h00, cfg_sel_r, cur_cfg_r, 6'h00, hs_mode,
                              configured_r};
    wire [31:0] alt_w      = {alt_r[3], alt_r[2], alt_r[1], alt_r[0]};
    wire [31:0] rd_val     = (rd_idx < 4'h8) ? cfg_r[rd_idx[2:0]] :
                             (rd_idx == 4'h8) ? status_w :
                             (rd_idx == 4'h9) ? alt_w : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `USBD_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= (rd_idx == 4'hf) ? `USBD_RESP_DECERR : `USBD_RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Shadowed so a set request needs no memory read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_sel_r <= `USBD_RST_CFG_SEL;
        end else if (win_wr && win_adr == AW'(`USBD_COFS_SEL)) begin
            cfg_sel_r <= w_data_r[7:0]; // [RULE10]
        end
    end

    usbd_pkg::usbd_state_e state_r;
    usbd_pkg::usbd_kind_e  kind_r, acc_kind;
    logic [15:0]           cnt_r, last_r;
    logic [7:0]            mem_rd;

    wire        req_fire = req_valid && req_ready;
    wire        is_get   = req_code == `USBD_REQ_GET_DESC;
    wire        is_scfg  = req_code == `USBD_REQ_SET_CFG;
    wire        is_sif   = req_code == `USBD_REQ_SET_IF;
    wire [7:0]  d_type   = req_value[15:8];
    wire        t_dev    = d_type == `USBD_TYPE_DEVICE;
    wire        t_qual   = d_type == `USBD_TYPE_QUAL; // [RULE9]
    wire        t_cfg    = d_type == `USBD_TYPE_CONFIG
                           && req_value[7:0] == 8'h00;
    // Other-speed and unknown types end in an error.
    wire        get_ok   = t_dev || t_cfg || (t_qual && hs_capable); // [RULE7] [RULE8]
    wire        scfg_ok  = req_value[7:0] == 8'h00
                           || req_value[7:0] == cfg_sel_r; // [RULE10]
    wire        sif_ok   = configured_r && req_index[15:8] == 8'h00
                           && req_index[7:0] < num_if_eff
                           && req_index[7:0] < 8'(NUM_ALT); // [RULE16]
    wire        acc_err  = is_get ? !get_ok : is_scfg ? !scfg_ok :
                           is_sif ? !sif_ok : 1'b1;
    wire [15:0] acc_len  = t_dev ? 16'(`USBD_DEV_LEN) :
                           t_qual ? 16'(`USBD_QUAL_LEN) : cfg_total;
    wire [15:0] xfer_len = (req_length < acc_len) ? req_length : acc_len; // [RULE20]
    wire        cfg_hit  = req_value[7:0] != 8'h00;

    assign acc_kind  = t_dev ? usbd_pkg::USBD_K_DEV :
                       t_qual ? usbd_pkg::USBD_K_QUAL : usbd_pkg::USBD_K_CFG;
    assign req_ready = state_r == usbd_pkg::USBD_IDLE;
    assign tx_valid  = state_r == usbd_pkg::USBD_SEND;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            configured_r <= 1'b0;
            cur_cfg_r    <= 8'h00;
        end else if (req_fire && is_scfg && scfg_ok) begin
            configured_r <= cfg_hit; // [RULE10]
            cur_cfg_r    <= req_value[7:0];
        end
    end

    // Interfaces 0 to 3 each keep their own alternate.
    for (g = 0; g < NUM_ALT; g++) begin : g_alt
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                alt_r[g] <= 8'h00;
            end else if (req_fire && is_scfg && scfg_ok) begin
                alt_r[g] <= 8'h00;
            end else if (req_fire && is_sif && sif_ok
                         && req_index[7:0] == 8'(g)) begin
                alt_r[g] <= req_value[7:0]; // [RULE15] [RULE16]
            end
        end
    end

    // Descriptor images, low byte first.
    wire [7:0]  ofs = cnt_r[7:0];
    logic [7:0] dev_b, qual_b, cfg_b;

    always_comb begin
        unique case (ofs)
            `USBD_OFS_LEN:    dev_b = `USBD_DEV_LEN;
            `USBD_OFS_TYPE:   dev_b = `USBD_TYPE_DEVICE;
            `USBD_OFS_W2_LO:  dev_b = ver[7:0]; // [RULE18] [RULE19]
            `USBD_OFS_W2_HI:  dev_b = ver[15:8];
            `USBD_OFS_CLASS:  dev_b = dev_class;
            `USBD_OFS_SUB:    dev_b = dev_sub;
            `USBD_OFS_PROTO:  dev_b = dev_proto;
            `USBD_OFS_MPS:    dev_b = mps_cur; // [RULE17]
            `USBD_OFS_VID_LO: dev_b = cfg_r[4][7:0]; // [RULE19]
            `USBD_OFS_VID_HI: dev_b = cfg_r[4][15:8];
            `USBD_OFS_PID_LO: dev_b = cfg_r[4][23:16];
            `USBD_OFS_PID_HI: dev_b = cfg_r[4][31:24];
            `USBD_OFS_REL_LO: dev_b = cfg_r[5][7:0]; // [RULE18]
            `USBD_OFS_REL_HI: dev_b = cfg_r[5][15:8];
            `USBD_OFS_IMFR:   dev_b = cfg_r[6][7:0]; // [RULE1]
            `USBD_OFS_IPROD:  dev_b = cfg_r[6][15:8]; // [RULE1]
            `USBD_OFS_ISER:   dev_b = cfg_r[6][23:16]; // [RULE1]
            `USBD_OFS_NCFG:   dev_b = `USBD_NUM_CONFIGS; // [RULE1] [RULE14]
            default:          dev_b = 8'h00;
        endcase
    end

    always_comb begin
        unique case (ofs)
            `USBD_OFS_LEN:    qual_b = `USBD_QUAL_LEN; // [RULE2] [RULE5]
            `USBD_OFS_TYPE:   qual_b = `USBD_TYPE_QUAL; // [RULE2]
            `USBD_OFS_W2_LO:  qual_b = qual_ver[7:0]; // [RULE6] [RULE19]
            `USBD_OFS_W2_HI:  qual_b = qual_ver[15:8];
            `USBD_OFS_CLASS:  qual_b = dev_class; // [RULE2]
            `USBD_OFS_SUB:    qual_b = dev_sub;
            `USBD_OFS_PROTO:  qual_b = dev_proto;
            `USBD_OFS_MPS:    qual_b = mps_oth; // [RULE4]
            `USBD_QOFS_NCFG:  qual_b = other_cfgs; // [RULE2] [RULE4]
            `USBD_QOFS_RSVD:  qual_b = 8'h00; // [RULE3]
            default:          qual_b = 8'h00;
        endcase
    end

    // Hardware-owned header fields override the image.
    always_comb begin
        cfg_b = mem_rd;
        if (cnt_r[15:8] == 8'h00) begin
            unique case (ofs)
                `USBD_OFS_LEN:   cfg_b = `USBD_CFG_LEN; // [RULE12]
                `USBD_OFS_TYPE:  cfg_b = `USBD_TYPE_CONFIG; // [RULE12]
                `USBD_OFS_W2_LO: cfg_b = cfg_total[7:0]; // [RULE13] [RULE19]
                `USBD_OFS_W2_HI: cfg_b = cfg_total[15:8];
                `USBD_COFS_NIF:  cfg_b = num_if_eff; // [RULE12] [RULE14]
                `USBD_COFS_SEL:  cfg_b = cfg_sel_r; // [RULE12]
                `USBD_COFS_ISTR: cfg_b = cfg_r[6][31:24]; // [RULE12]
                default:         cfg_b = mem_rd;
            endcase
        end
    end

    wire [7:0] byte_sel = (kind_r == usbd_pkg::USBD_K_DEV) ? dev_b :
                          (kind_r == usbd_pkg::USBD_K_QUAL) ? qual_b : cfg_b;

    usbd_mem #(
        .AW      (AW)
    ) u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (win_wr),
        .wr_addr (win_adr),
        .wr_data (w_data_r[7:0]),
        .rd_en   (state_r == usbd_pkg::USBD_FETCH),
        .rd_addr (cnt_r[AW-1:0]),
        .rd_data (mem_rd)
    );

    // Fetch, load, send: three cycles a byte.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r   <= usbd_pkg::USBD_IDLE;
            kind_r    <= usbd_pkg::USBD_K_DEV;
            cnt_r     <= 16'h0000;
            last_r    <= 16'h0000;
            tx_data   <= 8'h00;
            tx_last   <= 1'b0;
            req_done  <= 1'b0;
            req_error <= 1'b0;
        end else begin
            req_done  <= 1'b0;
            req_error <= 1'b0;
            unique case (state_r)
                usbd_pkg::USBD_IDLE: begin
                    if (req_fire) begin
                        if (acc_err) begin
                            req_error <= 1'b1; // [RULE7]
                        end else if (is_get && xfer_len != 16'h0000) begin
                            state_r <= usbd_pkg::USBD_FETCH;
                            kind_r  <= acc_kind;
                            cnt_r   <= 16'h0000;
                            last_r  <= xfer_len - 16'h0001; // [RULE20]
                        end else begin
                            req_done <= 1'b1;
                        end
                    end
                end
                usbd_pkg::USBD_FETCH: begin
                    state_r <= usbd_pkg::USBD_LOAD;
                end
                usbd_pkg::USBD_LOAD: begin
                    tx_data <= byte_sel;
                    tx_last <= cnt_r == last_r;
                    state_r <= usbd_pkg::USBD_SEND;
                end
                usbd_pkg::USBD_SEND: begin
                    if (tx_ready) begin
                        if (tx_last) begin
                            state_r  <= usbd_pkg::USBD_IDLE;
                            tx_last  <= 1'b0;
                            req_done <= 1'b1;
                        end else begin
                            cnt_r   <= cnt_r + 16'h0001; // [RULE11]
                            state_r <= usbd_pkg::USBD_FETCH;
                        end
                    end
                end
            endcase
        end
    end

endmodule : usbd_responder

// File: verif/usbd_resp_props.sv
`timescale 1ns/100ps
module usbd_resp_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [7:0]  req_code,
    input wire logic [15:0] req_value,
    input wire logic [15:0] req_length,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_last,
    input wire logic        req_done,
    input wire logic        req_error
);
    wire       tk = req_valid && req_ready;
    wire       gd = tk && req_code == 8'h06 && req_length != 16'h0;
    wire [7:0] ty = req_value[15:8];
    wire       hs = tx_valid && tx_ready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_dev; gd && ty == 8'h01 |-> ##3 tx_data == 8'h12; endproperty
    a_dev: assert property (p_dev) else $error("device head");
    property p_cfg; gd && ty == 8'h02 |-> ##3 tx_data == 8'h09; endproperty
    a_cfg: assert property (p_cfg) else $error("config head");
    property p_qual; gd && ty == 8'h06 |->
        (##1 req_error) or (##3 tx_data == 8'h0a); endproperty
    a_qual: assert property (p_qual) else $error("qualifier head");
    property p_osc; tk && req_code == 8'h06 && ty == 8'h07 |=> req_error;
    endproperty
    a_osc: assert property (p_osc) else $error("other speed");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_gap; hs && !tx_last |-> ##3 tx_valid; endproperty
    a_gap: assert property (p_gap) else $error("stream gap");
    property p_end; hs && tx_last |=> req_done && req_ready; endproperty
    a_end: assert property (p_end) else $error("no done");
    property p_set; tk && req_code == 8'h09 && req_value[7:0] == 8'h01
        |=> req_done && !req_error; endproperty
    a_set: assert property (p_set) else $error("set config");
endmodule : usbd_resp_props
bind usbd_responder usbd_resp_props i_props (.*);

// File: verif/usbd_host.sv
`timescale 1ns/100ps
module usbd_host (
    input  wire logic       aclk,
    input  wire logic       req_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       req_done,
    input  wire logic       req_error,
    output logic            req_valid = 1'h0,
    output logic [7:0]      req_code = 8'h00,
    output logic [15:0]     req_value = 16'h0,
    output logic [15:0]     req_length = 16'h0,
    output logic            tx_ready = 1'h1
);
    logic [7:0] rx[$];
    logic       slow = 1'h0;
    logic       err;
    always @(posedge aclk) tx_ready <= !slow || !tx_ready;
    always @(posedge aclk) if (tx_valid && tx_ready) rx.push_back(tx_data);
    task automatic ask(input logic [7:0] c, input logic [15:0] v, l);
        rx.delete();
        @(posedge aclk);
        req_code <= c;
        req_value <= v;
        req_length <= l;
        req_valid <= 1'h1;
        do @(negedge aclk); while (!req_ready);
        @(posedge aclk);
        req_valid <= 1'h0;
        // Released fields show garbage so a late sample cannot pass.
        {req_code, req_value, req_length} <= ~{c, v, l};
        do @(negedge aclk); while (!(req_done || req_error));
        err = req_error;
    endtask : ask
endmodule : usbd_host

// File: verif/usbd_responder_test.sv
`timescale 1ns/100ps
module usbd_responder_test;
    typedef struct {logic [7:0] c; logic [15:0] v, l;
                    int n, p; logic [7:0] b;} usbd_row_s;
    logic        aclk = 1'h0, aresetn = 1'h0, hs_mode = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] req_index = 16'h0, req_value, req_length;
    logic [7:0]  req_code, tx_data;
    logic        req_valid, req_ready, tx_valid, tx_ready, tx_last;
    logic        req_done, req_error;
    int          n_fail = 0, cmp_count = 0;
    // Count -1: request error expected.
    usbd_row_s rows[] = '{
        '{8'h06, 16'h0100, 16'h12, 18, 14, 8'h0d},
        '{8'h06, 16'h0100, 16'h12, 18, 17, 8'h01},
        '{8'h06, 16'h0100, 16'h12, 18, 3, 8'h01},
        '{8'h06, 16'h0100, 16'h05, 5, 4, 8'h00},
        '{8'h06, 16'h0600, 16'h40, 10, 9, 8'h00},
        '{8'h06, 16'h0600, 16'h40, 10, 3, 8'h02},
        '{8'h06, 16'h0600, 16'h40, 10, 7, 8'h08},
        '{8'h06, 16'h0600, 16'h40, 10, 8, 8'h02},
        '{8'h06, 16'h0200, 16'hffff, 32, 2, 8'h20},
        '{8'h06, 16'h0200, 16'h40, 32, 6, 8'h0a},
        '{8'h06, 16'h0200, 16'h40, 32, 7, 8'hc0},
        '{8'h06, 16'h0700, 16'h09, -1, 0, 8'h00},
        '{8'h09, 16'h0005, 16'h00, -1, 0, 8'h00},
        '{8'h09, 16'h0001, 16'h00, 0, 0, 8'h00}};
    usbd_responder i_dut (.*);
    usbd_host      i_host (.*);
    always #50 aclk = ~aclk;
    task automatic chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw = 1'h1, w = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd_reg(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        while (!s_axi_rvalid) @(posedge aclk);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask : rd_reg
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        #1_000_000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd_reg(12'h01c);
        chk(rd, 32'h0001_0009);
        wr(12'h004, 32'h0110);
        wr(12'h00c, 32'h0002_0840);
        wr(12'h018, 32'h0a0b_0c0d);
        wr(12'h01c, 32'h0002_0020);
        wr(12'h11c, 32'hc0);
        foreach (rows[i]) begin
            i_host.ask(rows[i].c, rows[i].v, rows[i].l);
            chk(i_host.err, rows[i].n < 0);
            if (rows[i].n >= 0) chk(i_host.rx.size(), rows[i].n);
            if (rows[i].n > 0) chk(i_host.rx[rows[i].p], rows[i].b);
        end
        rd_reg(12'h020);
        chk(rd[0], 1'h1);
        wr(12'h020, 32'h0);
        chk(rs, 2'h2);
        rd_reg(12'h0fc);
        chk(rs, 2'h3);
        hs_mode <= 1'h1;
        i_host.slow = 1'h1;
        i_host.ask(8'h06, 16'h0600, 16'h40);
        chk(i_host.rx[7], 8'h40);
        wr(12'h004, 32'h0200);
        wr(12'h000, 32'h0);
        i_host.ask(8'h06, 16'h0600, 16'h40);
        chk(i_host.err, 1'h1);
        final_report();
    end
endmodule : usbd_responder_test
